// >>> design/adcc_conv_ctrl.sv
// converter control: conversion clock divider, start-source select, busy/done tracking, reference control.
// assumes a 250 MHz ref_clk, APB master on the same clock, timer overflows as one-cycle pulses on ref_clk,
// and the analog sampler presenting its code on sampleData by the end of the conversion.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`include "adcc_params.svh"
module adcc_conv_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // start sources
  input  wire logic        tmr0Overflow,
  input  wire logic        tmr1Overflow,
  input  wire logic        tmr2LowOverflow,
  input  wire logic        tmr2HighOverflow,
  input  wire logic        extStartInput,
  // analog side
  input  wire logic [7:0]  sampleData,
  output logic             convClockEn,
  output logic             sampleStart,
  output logic             referenceSelect,
  output logic             tempSensorEnable,
  output logic             analogBiasEnable,
  output logic             convIrq
);
  import adcc_pkg::*;

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0]     ctrl_q;
  logic [7:0]     cfg_q;
  logic [7:0]     ref_q;
  logic [1:0]     misc_q;
  logic           busy_q;
  logic           done_q;
  logic [4:0]     divCnt_q;
  logic [4:0]     convCnt_q;
  logic           ext1_q;
  logic           ext2_q;
  logic           ext3_q;
  adcc_state_type state_q;
  logic [7:0]     resultData;
  logic           wrEn;
  logic           rdEn;
  logic           addrHit;
  logic           launch;
  logic           finish;
  logic           softStart;
  adcc_src_type   srcSel;

  // one-cycle access phase: zero wait states
  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && penable && !pwrite;
  assign srcSel  = adcc_src_type'(ctrl_q[`ADCC_CTL_SRC_HI:`ADCC_CTL_SRC_LO]);

  // decode a byte address into a hit on the mapped set
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == `ADCC_ADDR_CONV_CTRL) || (a == `ADCC_ADDR_CONV_CFG) ||
               (a == `ADCC_ADDR_RESULT) || (a == `ADCC_ADDR_MISC) ||
               (a == `ADCC_ADDR_REF_CTRL);
  endfunction : isMapped

  assign addrHit = isMapped(paddr);
  assign pslverr = psel && penable && !addrHit;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // busy and done live outside ctrl_q; those bit positions are stored here but read back from busy_q and done_q
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= `ADCC_RST_CTRL;
      cfg_q  <= `ADCC_RST_CFG;
      ref_q  <= `ADCC_RST_REF;
      misc_q <= 2'b00;
    end else if (wrEn) begin
      case (paddr)
        `ADCC_ADDR_CONV_CTRL: ctrl_q <= pwdata[7:0];
        `ADCC_ADDR_CONV_CFG:  cfg_q  <= pwdata[7:0];
        `ADCC_ADDR_REF_CTRL:  ref_q  <= pwdata[7:0] & `ADCC_REF_MASK;
        `ADCC_ADDR_MISC:      misc_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // reference and power steering straight from the register
  assign referenceSelect  = ref_q[`ADCC_REF_SEL];
  assign tempSensorEnable = ref_q[`ADCC_REF_TEMP];
  assign analogBiasEnable = ref_q[`ADCC_REF_BIAS];

  // ----------------------------------------------------------------
  // conversion clock divider
  // ----------------------------------------------------------------
  // counts down from the field value; a field of 0 gives an enable every cycle
  always_ff @(posedge ref_clk) begin
    if (srst || state_q != ST_CONV) begin
      divCnt_q <= cfg_q[`ADCC_CFG_DIV_HI:`ADCC_CFG_DIV_LO];
    end else if (divCnt_q == 5'd0) begin
      divCnt_q <= cfg_q[`ADCC_CFG_DIV_HI:`ADCC_CFG_DIV_LO];
    end else begin
      divCnt_q <= divCnt_q - 5'd1;
    end
  end

  assign convClockEn = (state_q == ST_CONV) && (divCnt_q == 5'd0);

  // ----------------------------------------------------------------
  // external start synchroniser and edge detect
  // ----------------------------------------------------------------
  // pin is asynchronous: two flops first, edge taken from the second and third
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext1_q <= 1'b0;
      ext2_q <= 1'b0;
      ext3_q <= 1'b0;
    end else begin
      ext1_q <= extStartInput;
      ext2_q <= ext1_q;
      ext3_q <= ext2_q;
    end
  end

  // ----------------------------------------------------------------
  // start source selection
  // ----------------------------------------------------------------
  assign softStart = wrEn && (paddr == `ADCC_ADDR_CONV_CTRL) && pwdata[`ADCC_CTL_BUSY];

  // only the selected source may launch; the bias generator must be on
  always_comb begin
    launch = 1'b0;
    case (srcSel)
      SRC_SOFT:   launch = softStart;
      SRC_TMR0:   launch = tmr0Overflow;
      SRC_TMR1:   launch = tmr1Overflow;
      SRC_TMR2:   launch = misc_q[`ADCC_MISC_T2_16] ? tmr2HighOverflow : tmr2LowOverflow;
      SRC_EXTPIN: launch = ext2_q && !ext3_q;
      default:    launch = 1'b0;
    endcase
    launch = launch && ctrl_q[`ADCC_CTL_ENABLE] && analogBiasEnable;
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // starts that arrive during a conversion are dropped, not queued
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q   <= ST_IDLE;
      convCnt_q <= 5'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            state_q   <= ST_CONV;
            convCnt_q <= `ADCC_CONV_CLOCKS;
          end
        end
        ST_CONV: begin
          if (convClockEn) begin
            if (convCnt_q == 5'd1) begin
              state_q <= ST_DONE;
            end
            convCnt_q <= convCnt_q - 5'd1;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign finish      = (state_q == ST_DONE);
  assign sampleStart = (state_q == ST_IDLE) && launch;

  // busy follows the conversion
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else if (sampleStart) begin
      busy_q <= 1'b1;
    end else if (finish) begin
      busy_q <= 1'b0;
    end
  end

  // done sets on busy falling; set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (wrEn && paddr == `ADCC_ADDR_CONV_CTRL && !pwdata[`ADCC_CTL_DONE]) begin
      done_q <= 1'b0;
    end else if (sampleStart) begin
      done_q <= 1'b0;  // result about to change, so done must not claim validity
    end
  end

  assign convIrq = done_q && misc_q[`ADCC_MISC_IE];

  // result captured on the same edge that done sets
  adcc_result_reg u_result (
    .ref_clk (ref_clk),
    .srst    (srst),
    .load    (finish),
    .dataIn  (sampleData),
    .dataOut (resultData)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // registered so read data meets the access edge cleanly
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `ADCC_ADDR_CONV_CTRL: prdata <= {24'h000000, ctrl_q[7:6], done_q, busy_q, 1'b0, ctrl_q[2:0]};
        `ADCC_ADDR_CONV_CFG:  prdata <= {24'h000000, cfg_q};
        `ADCC_ADDR_RESULT:    prdata <= {24'h000000, resultData};
        `ADCC_ADDR_MISC:      prdata <= {30'h00000000, misc_q};
        `ADCC_ADDR_REF_CTRL:  prdata <= {24'h000000, ref_q};
        default:              prdata <= 32'h00000000;
      endcase
    end
  end

  // rdEn kept for clarity of the read strobe; reads have no side effect
  logic unusedRd;
  assign unusedRd = rdEn;
endmodule : adcc_conv_ctrl

// >>> common/adcc_params.svh
// constants for the converter control block: register offsets, field positions, reset values, timing.
// assumes a 32-bit APB register bus where each register takes one aligned word.
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// byte addresses on APB (reference control index 0xD1, others chosen)
`define ADCC_IDX_REF_CTRL     8'hD1
`define ADCC_ADDR_REF_CTRL    12'h344
`define ADCC_ADDR_CONV_CTRL   12'h000
`define ADCC_ADDR_CONV_CFG    12'h004
`define ADCC_ADDR_RESULT      12'h008
`define ADCC_ADDR_MISC        12'h00C

// converter control fields
`define ADCC_CTL_ENABLE       7
`define ADCC_CTL_DONE         5
`define ADCC_CTL_BUSY         4
`define ADCC_CTL_SRC_LO       0
`define ADCC_CTL_SRC_HI       2
// converter config fields
`define ADCC_CFG_DIV_LO       3
`define ADCC_CFG_DIV_HI       7
// reference control fields
`define ADCC_REF_SEL          3
`define ADCC_REF_TEMP         2
`define ADCC_REF_BIAS         1
`define ADCC_REF_MASK         8'h0E
// misc fields
`define ADCC_MISC_IE          0
`define ADCC_MISC_T2_16       1

// reset values
`define ADCC_RST_CTRL         8'h00
`define ADCC_RST_CFG          8'hF8
`define ADCC_RST_REF          8'h00

// conversion length in divided conversion clocks
`define ADCC_CONV_CLOCKS      5'd11
`define ADCC_RESULT_W         8

`endif

// >>> common/adcc_pkg.sv
// types for the converter control block.
// assumes adcc_params.svh supplies all numeric constants.
package adcc_pkg;
  typedef enum logic [2:0] {
    SRC_SOFT   = 3'h0,
    SRC_TMR0   = 3'h1,
    SRC_TMR2   = 3'h2,
    SRC_TMR1   = 3'h3,
    SRC_EXTPIN = 3'h4
  } adcc_src_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_DONE
  } adcc_state_type;
endpackage : adcc_pkg

// >>> design/adcc_result_reg.sv
// result holding register: loads the converted word when the conversion ends.
// assumes load is a one-cycle pulse on ref_clk.
`timescale 1ns/10ps
module adcc_result_reg (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       load,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut
);
  // read data straight from a register, so a read never sees a moving sample
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dataOut <= 8'h00;
    end else if (load) begin
      dataOut <= dataIn;
    end
  end
endmodule : adcc_result_reg

// >>> test/adcc_chk.sv
// checker: timing relations at the converter control ports.
// assumes one clock domain; srst is synchronous and active high.
`timescale 1ns/10ps
module adcc_chk (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        convClockEn,
  input wire logic        sampleStart,
  input wire logic        referenceSelect,
  input wire logic        tempSensorEnable,
  input wire logic        analogBiasEnable,
  input wire logic        convIrq
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // completed write to reference control and its three live bits
  wire logic refWr = psel && penable && pwrite && paddr == 12'h344;
  wire logic wSel  = pwdata[3];
  wire logic wTemp = pwdata[2];
  wire logic wBias = pwdata[1];
  ref_select_a: assert property (refWr |=> referenceSelect == $past(wSel))
    else $error("reference select did not follow write");
  temp_enable_a: assert property (refWr |=> tempSensorEnable == $past(wTemp))
    else $error("sensor enable did not follow write");
  bias_enable_a: assert property (refWr |=> analogBiasEnable == $past(wBias))
    else $error("bias enable did not follow write");
  bias_gate_a: assert property (sampleStart |-> analogBiasEnable)
    else $error("launch with bias generator off");
  start_gap_a: assert property (sampleStart |=> !sampleStart [*8])
    else $error("second launch during conversion");
  first_tick_a: assert property (sampleStart |-> ##[1:32] convClockEn)
    else $error("no conversion clock after launch");
  tick_idle_a: assert property (convClockEn |-> !sampleStart)
    else $error("conversion clock in launch cycle");
  irq_cause_a: assert property ($rose(convIrq) |-> $past(convClockEn, 1) || $past(convClockEn, 2)
    || $past(convClockEn, 3))
    else $error("interrupt without a finished conversion");
  start_clears_a: assert property (sampleStart |=> !convIrq)
    else $error("interrupt held across a new launch");
endmodule : adcc_chk

bind adcc_conv_ctrl adcc_chk adcc_chk_inst (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .convClockEn, .sampleStart, .referenceSelect, .tempSensorEnable, .analogBiasEnable, .convIrq);

// >>> test/adcc_far_model.sv
// far side model: timers, external start pin and the analog sampler.
// assumes fireSel is held for one cycle: 1 t0, 2 t2 low, 3 t1, 4 pin, 5 t2 high.
`timescale 1ns/10ps
module adcc_far_model (
  input  wire logic       ref_clk,
  input  wire logic [2:0] fireSel,
  input  wire logic [7:0] codeIn,
  output logic            tmr0Overflow = 1'b0,
  output logic            tmr1Overflow = 1'b0,
  output logic            tmr2LowOverflow = 1'b0,
  output logic            tmr2HighOverflow = 1'b0,
  output logic            extStartInput,
  output logic [7:0]      sampleData
);
  // ------------------------------
  // stimulus sources
  // ------------------------------
  logic [2:0] pinCnt_q = 3'h0;
  // overflows are single-cycle pulses; the pin stays high a few cycles so the synchroniser sees it
  always @(posedge ref_clk) begin
    tmr0Overflow     <= fireSel == 3'h1;
    tmr2LowOverflow  <= fireSel == 3'h2;
    tmr1Overflow     <= fireSel == 3'h3;
    tmr2HighOverflow <= fireSel == 3'h5;
    pinCnt_q         <= (fireSel == 3'h4) ? 3'h4 : pinCnt_q - {2'h0, pinCnt_q != 3'h0};
  end
  assign extStartInput = pinCnt_q != 3'h0;
  assign sampleData    = codeIn;
endmodule : adcc_far_model

// >>> test/tb.sv
// testbench: register access, every start source, divider timing, masking and reset.
// assumes the far side model supplies timer pulses, the start pin and the sampled code.
`timescale 1ns/10ps
module tb;
  import adcc_pkg::*;
  typedef struct { logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e; } adcc_row_type;
  logic        ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, expIe = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, tmr0Overflow, tmr1Overflow, tmr2LowOverflow, tmr2HighOverflow, extStartInput;
  logic        convClockEn, sampleStart, referenceSelect, tempSensorEnable, analogBiasEnable, convIrq;
  logic [7:0]  sampleData, codeIn = 8'h00;
  logic [2:0]  fireSel = 3'h0;
  int          mismatches = 0, num_checks = 0, starts = 0, ticks = 0, gapBad = 0, cyc = 0, prev = 0, expGap = 1, s0, t0;
  adcc_row_type rows [5] = '{'{12'h344, 32'hFFFFFFFF, 32'h0E, 1'b0}, '{12'h004, 32'h55, 32'h55, 1'b0},
    '{12'h00C, 32'h3, 32'h3, 1'b0}, '{12'h008, 32'hFF, 32'h0, 1'b0}, '{12'h010, 32'hFF, 32'h0, 1'b1}};
  // ------------------------------
  // design, far side, clock
  // ------------------------------
  adcc_conv_ctrl adcc_conv_ctrl_inst (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tmr0Overflow, .tmr1Overflow, .tmr2LowOverflow, .tmr2HighOverflow, .extStartInput, .sampleData,
    .convClockEn, .sampleStart, .referenceSelect, .tempSensorEnable, .analogBiasEnable, .convIrq);
  adcc_far_model adcc_far_model_inst (.ref_clk, .fireSel, .codeIn, .tmr0Overflow, .tmr1Overflow,
    .tmr2LowOverflow, .tmr2HighOverflow, .extStartInput, .sampleData);
  always #2 ref_clk = ~ref_clk;
  // launch and tick monitor: each tick gap must be divider plus one
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (sampleStart === 1'b1) begin
      starts <= starts + 1;
      prev   <= cyc;
    end
    if (convClockEn === 1'b1) begin
      ticks  <= ticks + 1;
      prev   <= cyc;
      gapBad <= gapBad + int'(cyc - prev != expGap);
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // one apb transfer; ready is awaited, never assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic trig(input logic [2:0] f);
    if (f == 3'h0) begin
      apb(1'b1, 12'h000, 32'h90);
    end else begin
      fireSel <= f;
      @(posedge ref_clk);
      fireSel <= 3'h0;
    end
  endtask : trig
  task automatic conv(input adcc_src_type src, input logic [2:0] f, input logic [4:0] dv, input logic [7:0] code);
    int n;
    n      = 0;
    codeIn <= code;
    expGap = dv + 1;
    apb(1'b1, 12'h004, {24'h0, dv, 3'h0});
    apb(1'b1, 12'h000, {24'h0, 5'h10, src});
    s0 = starts;
    t0 = ticks;
    trig(f);
    do begin
      apb(1'b0, 12'h000, 32'h0);
      if (n == 0 && src == SRC_SOFT) chk(rd[4], 1'b1);
      n++;
    end while (rd[5] !== 1'b1 && n < 200);
    if (n >= 200) mismatches++;
    chk(starts - s0, 1);
    chk(ticks - t0, 11);
    chk(rd[4], 1'b0);
    chk(convIrq, expIe);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, code);
    apb(1'b1, 12'h000, {24'h0, 5'h10, src});
  endtask : conv
  task automatic noStart(input adcc_src_type src, input logic [2:0] f);
    apb(1'b1, 12'h000, {24'h0, 5'h10, src});
    s0 = starts;
    trig(f);
    repeat (8) @(posedge ref_clk);
    chk(starts - s0, 0);
  endtask : noStart
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'hF8);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].q);
      chk(err, rows[i].e);
    end
    chk({referenceSelect, tempSensorEnable, analogBiasEnable}, 3'b111);
    apb(1'b1, 12'h344, 32'h2);
    chk({referenceSelect, tempSensorEnable, analogBiasEnable}, 3'b001);
    apb(1'b1, 12'h00C, 32'h1);
    expIe = 1'b1;
    conv(SRC_SOFT, 3'h0, 5'd3, 8'hA5);
    conv(SRC_TMR0, 3'h1, 5'd0, 8'h3C);
    conv(SRC_TMR1, 3'h3, 5'd31, 8'hC3);
    conv(SRC_TMR2, 3'h2, 5'd0, 8'h5A);
    conv(SRC_EXTPIN, 3'h4, 5'd1, 8'h81);
    noStart(SRC_TMR0, 3'h3);
    apb(1'b1, 12'h00C, 32'h3);
    noStart(SRC_TMR2, 3'h2);
    conv(SRC_TMR2, 3'h5, 5'd0, 8'h7E);
    apb(1'b1, 12'h00C, 32'h2);
    expIe = 1'b0;
    conv(SRC_SOFT, 3'h0, 5'd2, 8'h18);
    apb(1'b1, 12'h344, 32'h0);
    noStart(SRC_SOFT, 3'h0);
    // reset in mid conversion must clear the interrupt, reference select, bias enable and the control and reference registers
    apb(1'b1, 12'h344, 32'hE);
    trig(3'h0);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    chk({convIrq, referenceSelect, analogBiasEnable}, 3'b000);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h344, 32'h0);
    chk(rd, 32'h0);
    chk(gapBad, 0);
    print_verdict();
  end
endmodule : tb
